// >>> include/acr_params.svh
// Register map constants for the converter configuration bank.
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
`define ACR_IDX_MASK 8'h05
`define ACR_IDX_MODES 8'h08
`define ACR_IDX_CLOCK 8'h09
`define ACR_IDX_TEST 8'h0D
`define ACR_IDX_OFMT 8'h14
`define ACR_IDX_UPAT_LO 8'h19
`define ACR_IDX_UPAT_HI 8'h1A
`define ACR_IDX_XFER 8'hFF
`define ACR_RST_MASK 8'h0F
`define ACR_RST_MODES 8'h00
`define ACR_RST_CLOCK 8'h01
`define ACR_RST_TEST 8'h00
`define ACR_RST_OFMT 8'h00
`define ACR_RST_UPAT 8'h00
`define ACR_RST_XFER 8'h00
`define ACR_WM_MASK 8'h3F
`define ACR_WM_MODES 8'h07
`define ACR_WM_CLOCK 8'h01
`define ACR_WM_OFMT 8'h47
`define ACR_BIT_XFER 0
`define ACR_BIT_DCS 0
`define ACR_BIT_LPLVDS 6
`define ACR_BIT_INV 2
`define ACR_BIT_FMT 0
`define ACR_BIT_PNL_RST 5
`define ACR_BIT_PNS_RST 4
`define ACR_PN23_SEED 23'h7FFFFF
`define ACR_PN9_SEED 9'h1FF
`endif

// >>> include/acr_pkg.sv
// Types shared by the configuration bank and its pattern generator.
package acr_pkg;
    typedef enum logic [3:0] {
        TM_OFF = 4'h0,
        TM_MID = 4'h1,
        TM_PFS = 4'h2,
        TM_NFS = 4'h3,
        TM_CHECK = 4'h4,
        TM_PN23 = 4'h5,
        TM_PN9 = 4'h6,
        TM_WTOG = 4'h7,
        TM_USER = 4'h8,
        TM_BTOG = 4'h9,
        TM_SYNC = 4'hA,
        TM_ONEHI = 4'hB,
        TM_MIXED = 4'hC
    } acr_tmode_t;
endpackage : acr_pkg

// >>> core/acr_pattern_gen.sv
// Per-channel test pattern generator and output formatter.
`timescale 1ns/1ps
`include "acr_params.svh"
module acr_pattern_gen #(
    parameter int DW = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire acr_pkg::acr_tmode_t mode,
    input wire logic pn_long_rst,
    input wire logic pn_short_rst,
    input wire logic twos,
    input wire logic invert,
    input wire logic [15:0] user_pat,
    input wire logic [DW-1:0] conv_data,
    output logic [DW-1:0] data_out,
    output logic test_on
);
    import acr_pkg::*;

    logic [22:0] pn23_r;
    logic [8:0] pn9_r;
    logic tog_r;
    logic [DW-1:0] alt_p;
    logic [DW-1:0] sync_p;
    logic [DW-1:0] raw;
    logic [DW-1:0] fmt;

    if (DW < 10 || DW > 16) begin : g_bad
        $error("acr_pattern_gen: DW must lie in 10..16");
    end

    for (genvar i = 0; i < DW; i++) begin : g_bits
        assign alt_p[i] = 1'(i % 2);
        assign sync_p[i] = 1'(i >= DW / 2);
    end

    // Each sequence has its own shift register so switching modes never disturbs the other.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pn23_r <= `ACR_PN23_SEED;
        end else if (ce) begin
            if (pn_long_rst) begin
                pn23_r <= `ACR_PN23_SEED; // RL7
            end else begin
                pn23_r <= {pn23_r[21:0], pn23_r[22] ^ pn23_r[17]}; // RL7
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pn9_r <= `ACR_PN9_SEED;
        end else if (ce) begin
            if (pn_short_rst) begin
                pn9_r <= `ACR_PN9_SEED; // RL7
            end else begin
                pn9_r <= {pn9_r[7:0], pn9_r[8] ^ pn9_r[4]}; // RL7
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_r <= 1'b0;
        end else if (ce) begin
            tog_r <= ~tog_r;
        end
    end

    always_comb begin
        unique case (mode)
            TM_MID: raw = {1'b1, {(DW-1){1'b0}}}; // RL5
            TM_PFS: raw = {DW{1'b1}};
            TM_NFS: raw = {DW{1'b0}};
            TM_CHECK: raw = tog_r ? alt_p : ~alt_p;
            TM_PN23: raw = pn23_r[22 -: DW]; // RL7
            TM_PN9: raw = {pn9_r, pn9_r[8 -: (DW-9)]}; // RL7
            TM_WTOG: raw = {DW{tog_r}}; // RL8
            TM_USER: raw = user_pat[15 -: DW]; // RL8
            TM_BTOG: raw = alt_p;
            TM_SYNC: raw = sync_p;
            TM_ONEHI: raw = {{(DW-1){1'b0}}, 1'b1};
            TM_MIXED: raw = alt_p ^ sync_p;
            default: raw = conv_data; // RL6
        endcase
    end

    // Patterns are built in offset binary and pass the same formatter as live data.
    always_comb begin
        fmt = raw;
        if (twos) begin
            fmt[DW-1] = ~raw[DW-1]; // RL9
        end
        if (invert) begin
            fmt = ~fmt; // RL9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out <= '0;
            test_on <= 1'b0;
        end else if (ce) begin
            data_out <= fmt; // RL6
            test_on <= (mode != TM_OFF); // RL6
        end
    end

    property p_test_flag;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode != TM_OFF) |=> test_on;
    endproperty
    a_test_flag: assert property (p_test_flag) else $error("test flag not raised"); // RL6

    property p_normal_pass;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode == TM_OFF && !twos && !invert) |=> data_out == $past(conv_data);
    endproperty
    a_normal_pass: assert property (p_normal_pass) else $error("normal data lost"); // RL5

    property p_pn_hold;
        @(posedge pclk) disable iff (!presetn)
        (ce && pn_long_rst) |=> pn23_r == `ACR_PN23_SEED;
    endproperty
    a_pn_hold: assert property (p_pn_hold) else $error("long sequence not reset"); // RL7

    sequence s_wtog2;
        (ce && mode == TM_WTOG) ##1 (ce && mode == TM_WTOG && $stable({twos, invert}));
    endsequence
    property p_word_toggle;
        @(posedge pclk) disable iff (!presetn)
        s_wtog2 |=> data_out == ~$past(data_out);
    endproperty
    a_word_toggle: assert property (p_word_toggle) else $error("word toggle stuck"); // RL8

    property p_twos_fs;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode == TM_PFS && twos && !invert) |=> data_out == {1'b0, {(DW-1){1'b1}}};
    endproperty
    a_twos_fs: assert property (p_twos_fs) else $error("twos format not applied"); // RL9
endmodule : acr_pattern_gen

// >>> core/acr_regs.sv
// APB configuration register bank for a four-channel converter output path.
// Functional notes
// [RL1] Per-channel mask selects which channels take writes.
// [RL2] Clock channel select bits 5 and 4, default off.
// [RL3] Transfer bit copies staged settings into active.
// [RL4] Clock bit 0 enables duty stabilizer, default on.
// [RL5] Four-bit test mode field, zero means normal.
// [RL6] Nonzero test mode replaces conversion data on outputs; codes 1101 to 1111 still pass conversion data here.
// [RL7] Codes 0101 and 0110 give PN23 and PN9.
// [RL8] Code 0111 toggles words, 1000 sends user pattern.
// [RL9] Test patterns follow the selected output data format.
// [RL10] Output mode: low-power, invert, offset or twos.
// [RL11] User pattern held as low and high bytes.
`timescale 1ns/1ps
`include "acr_params.svh"
module acr_regs #(
    parameter int NCH = 4,
    parameter int DW = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH*DW-1:0] conv_data,
    output logic [NCH*DW-1:0] chan_data_out,
    output logic [NCH-1:0] test_active,
    output logic dcs_enable,
    output logic lvds_low_power,
    output logic [2:0] chip_mode,
    output logic data_clock_out_select,
    output logic frame_clock_out_select
);
    import acr_pkg::*;

    // ******************************************
    // Storage
    // ******************************************
    logic [7:0] mask_r;
    logic [7:0] xfer_r;
    logic [2:0] stg_modes_r;
    logic [2:0] act_modes_r;
    logic stg_clk_r;
    logic act_clk_r;
    logic [7:0] stg_omode_r;
    logic [7:0] act_omode_r;
    logic [15:0] stg_upat_r;
    logic [15:0] act_upat_r;
    logic [7:0] stg_test_r [NCH];
    logic [7:0] act_test_r [NCH];
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic setup;
    logic wr_go;
    logic [7:0] idx;
    logic idx_ok;
    logic [7:0] rd_data;
    logic rd_hit;
    logic commit;

    if (NCH < 1 || NCH > 4) begin : g_bad
        $error("acr_regs: NCH must lie in 1..4");
    end

    // ******************************************
    // Bus slave
    // ******************************************
    assign setup = psel && !penable;
    assign idx = paddr[9:2];
    assign idx_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign wr_go = ce && psel && penable && pready_r && pwrite && idx_ok;
    assign commit = ce && xfer_r[`ACR_BIT_XFER];

    always_comb begin
        rd_data = 8'h00;
        rd_hit = idx_ok;
        unique case (idx)
            `ACR_IDX_MASK: rd_data = mask_r;
            `ACR_IDX_MODES: rd_data = {5'h00, stg_modes_r};
            `ACR_IDX_CLOCK: rd_data = {7'h00, stg_clk_r};
            `ACR_IDX_TEST: rd_data = stg_test_r[0];
            `ACR_IDX_OFMT: rd_data = stg_omode_r;
            `ACR_IDX_UPAT_LO: rd_data = stg_upat_r[7:0];
            `ACR_IDX_UPAT_HI: rd_data = stg_upat_r[15:8];
            `ACR_IDX_XFER: rd_data = xfer_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // A registered ready keeps every bus output on a flop and still adds no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (ce) begin
            pready_r <= setup;
            pslverr_r <= setup && !rd_hit;
            prdata_r <= (setup && !pwrite) ? {24'h00_0000, rd_data} : 32'h0000_0000;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

    // ******************************************
    // Global registers
    // ******************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `ACR_RST_MASK;
        end else if (wr_go && idx == `ACR_IDX_MASK) begin
            mask_r <= pwdata[7:0] & `ACR_WM_MASK; // RL1 RL2
        end
    end

    // Set by software, cleared by hardware one enabled cycle later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_r <= `ACR_RST_XFER;
        end else if (wr_go && idx == `ACR_IDX_XFER) begin
            xfer_r <= {7'h00, pwdata[`ACR_BIT_XFER]}; // RL3
        end else if (commit) begin
            xfer_r <= `ACR_RST_XFER; // RL3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stg_modes_r <= 3'(`ACR_RST_MODES);
            stg_clk_r <= 1'(`ACR_RST_CLOCK);
            stg_omode_r <= `ACR_RST_OFMT;
        end else if (wr_go) begin
            if (idx == `ACR_IDX_MODES) begin
                stg_modes_r <= pwdata[2:0] & 3'(`ACR_WM_MODES);
            end
            if (idx == `ACR_IDX_CLOCK) begin
                stg_clk_r <= pwdata[`ACR_BIT_DCS]; // RL4
            end
            if (idx == `ACR_IDX_OFMT) begin
                stg_omode_r <= pwdata[7:0] & `ACR_WM_OFMT; // RL10
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stg_upat_r <= {`ACR_RST_UPAT, `ACR_RST_UPAT};
        end else if (wr_go) begin
            if (idx == `ACR_IDX_UPAT_LO) begin
                stg_upat_r[7:0] <= pwdata[7:0]; // RL11
            end
            if (idx == `ACR_IDX_UPAT_HI) begin
                stg_upat_r[15:8] <= pwdata[7:0]; // RL11
            end
        end
    end

    // Staged values reach the datapath only on a transfer, so a half-written setup never shows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_modes_r <= 3'(`ACR_RST_MODES);
            act_clk_r <= 1'(`ACR_RST_CLOCK);
            act_omode_r <= `ACR_RST_OFMT;
            act_upat_r <= {`ACR_RST_UPAT, `ACR_RST_UPAT};
        end else if (commit) begin
            act_modes_r <= stg_modes_r; // RL3
            act_clk_r <= stg_clk_r; // RL3 RL4
            act_omode_r <= stg_omode_r; // RL3 RL10
            act_upat_r <= stg_upat_r; // RL3 RL11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dcs_enable <= 1'(`ACR_RST_CLOCK);
            lvds_low_power <= 1'b0;
            chip_mode <= 3'(`ACR_RST_MODES);
            data_clock_out_select <= 1'b0;
            frame_clock_out_select <= 1'b0;
        end else if (ce) begin
            dcs_enable <= act_clk_r; // RL4
            lvds_low_power <= act_omode_r[`ACR_BIT_LPLVDS]; // RL10
            chip_mode <= act_modes_r;
            data_clock_out_select <= mask_r[5]; // RL2
            frame_clock_out_select <= mask_r[4]; // RL2
        end
    end

    // ******************************************
    // Channels
    // ******************************************
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stg_test_r[c] <= `ACR_RST_TEST;
            end else if (wr_go && idx == `ACR_IDX_TEST && mask_r[c]) begin
                stg_test_r[c] <= pwdata[7:0]; // RL1 RL5
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                act_test_r[c] <= `ACR_RST_TEST;
            end else if (commit) begin
                act_test_r[c] <= stg_test_r[c]; // RL3
            end
        end

        acr_pattern_gen #(
            .DW(DW)
        ) u_gen (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .mode(acr_tmode_t'(act_test_r[c][3:0])), // RL5
            .pn_long_rst(act_test_r[c][`ACR_BIT_PNL_RST]),
            .pn_short_rst(act_test_r[c][`ACR_BIT_PNS_RST]),
            .twos(act_omode_r[`ACR_BIT_FMT]), // RL9
            .invert(act_omode_r[`ACR_BIT_INV]), // RL9
            .user_pat(act_upat_r),
            .conv_data(conv_data[c*DW +: DW]),
            .data_out(chan_data_out[c*DW +: DW]),
            .test_on(test_active[c])
        );

        property p_test_gate;
            @(posedge pclk) disable iff (!presetn)
            (wr_go && idx == `ACR_IDX_TEST && !mask_r[c]) |=> $stable(stg_test_r[c]);
        endproperty
        a_test_gate: assert property (p_test_gate) else $error("unselected channel written"); // RL1
    end

    // ******************************************
    // Checks
    // ******************************************
    property p_ready;
        @(posedge pclk) disable iff (!presetn)
        (ce && setup) |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready missing after setup");

    property p_mask_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && idx == `ACR_IDX_MASK) |=> mask_r[3:0] == $past(pwdata[3:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask not written"); // RL1

    property p_clk_sel;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && idx == `ACR_IDX_MASK) ##1 ce |=> data_clock_out_select == $past(pwdata[5], 2);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock select lost"); // RL2

    sequence s_commit;
        ce && xfer_r[0];
    endsequence
    property p_commit;
        @(posedge pclk) disable iff (!presetn)
        s_commit |=> (act_modes_r == $past(stg_modes_r))
            && (!xfer_r[0] || $past(wr_go && idx == `ACR_IDX_XFER));
    endproperty
    a_commit: assert property (p_commit) else $error("transfer did not commit"); // RL3

    property p_no_early;
        @(posedge pclk) disable iff (!presetn)
        !xfer_r[0] |=> $stable(act_omode_r) && $stable(act_clk_r);
    endproperty
    a_no_early: assert property (p_no_early) else $error("active changed without transfer"); // RL3

    property p_dcs;
        @(posedge pclk) disable iff (!presetn)
        s_commit ##1 ce |=> dcs_enable == $past(stg_clk_r, 2);
    endproperty
    a_dcs: assert property (p_dcs) else $error("stabilizer enable wrong"); // RL4

    property p_lvds;
        @(posedge pclk) disable iff (!presetn)
        s_commit ##1 ce |=> lvds_low_power == $past(stg_omode_r[6], 2);
    endproperty
    a_lvds: assert property (p_lvds) else $error("low power select wrong"); // RL10

    property p_upat;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && idx == `ACR_IDX_UPAT_HI) |=> stg_upat_r[15:8] == $past(pwdata[7:0]);
    endproperty
    a_upat: assert property (p_upat) else $error("user pattern high byte lost"); // RL11
endmodule : acr_regs

// >>> verif/acr_host_model.sv
// APB host model that issues register transfers to the configuration bank.
`timescale 1ns/1ps
module acr_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // Each call starts on a fresh rising edge, so a release and the next setup never
    // share a time step. Released address and data are inverted so stale values never
    // look like a live request.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~{2'h0, idx, 2'h0};
        pwdata <= ~{24'h000000, wd};
    endtask : xfer
endmodule : acr_host_model

// >>> verif/tb_adc_channel_config_regs.sv
// Self-checking bench for the converter configuration register bank.
`timescale 1ns/1ps
module tb_adc_channel_config_regs;
    localparam int NCH = 4;
    localparam int DW = 12;
    typedef struct packed {
        logic wr;
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
        logic err;
    } acr_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dcs_enable, lvds_low_power;
    logic data_clock_out_select, frame_clock_out_select;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [NCH*DW-1:0] conv_data, chan_data_out;
    logic [NCH-1:0] test_active;
    logic [2:0] chip_mode;
    logic [7:0] rdv;
    logic errv;
    logic ce;
    logic [DW-1:0] v1, v2;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    acr_row_t rows [23];

    acr_host_model i_acr_host_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    acr_regs #(.NCH(NCH), .DW(DW)) i_acr_regs (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_data(conv_data),
        .chan_data_out(chan_data_out), .test_active(test_active), .dcs_enable(dcs_enable),
        .lvds_low_power(lvds_low_power), .chip_mode(chip_mode),
        .data_clock_out_select(data_clock_out_select),
        .frame_clock_out_select(frame_clock_out_select));

    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // A hung handshake would otherwise stall the run forever.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        i_acr_host_model.xfer(1'b1, idx, wd, rdv, errv);
        chk(16'(errv), 16'h0000, "write err");
    endtask : wr

    task automatic settle();
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    function automatic logic [DW-1:0] ch(input int c);
        return chan_data_out[c*DW +: DW];
    endfunction : ch

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rows = '{
            '{1'h0, 8'h05, 8'h00, 8'h0F, 1'h0},
            '{1'h0, 8'h08, 8'h00, 8'h00, 1'h0},
            '{1'h0, 8'h09, 8'h00, 8'h01, 1'h0},
            '{1'h0, 8'h0D, 8'h00, 8'h00, 1'h0},
            '{1'h0, 8'h14, 8'h00, 8'h00, 1'h0},
            '{1'h0, 8'h19, 8'h00, 8'h00, 1'h0},
            '{1'h0, 8'h1A, 8'h00, 8'h00, 1'h0},
            '{1'h0, 8'hFF, 8'h00, 8'h00, 1'h0},
            '{1'h0, 8'h03, 8'h00, 8'h00, 1'h1},
            '{1'h1, 8'h40, 8'hAA, 8'h00, 1'h1},
            '{1'h1, 8'h05, 8'hFF, 8'h00, 1'h0},
            '{1'h0, 8'h05, 8'h00, 8'h3F, 1'h0},
            '{1'h1, 8'h08, 8'hFF, 8'h00, 1'h0},
            '{1'h0, 8'h08, 8'h00, 8'h07, 1'h0},
            '{1'h1, 8'h14, 8'hFF, 8'h00, 1'h0},
            '{1'h0, 8'h14, 8'h00, 8'h47, 1'h0},
            '{1'h1, 8'h05, 8'h0E, 8'h00, 1'h0},
            '{1'h1, 8'h0D, 8'h04, 8'h00, 1'h0},
            '{1'h0, 8'h0D, 8'h00, 8'h00, 1'h0},
            '{1'h1, 8'h05, 8'h0F, 8'h00, 1'h0},
            '{1'h1, 8'h0D, 8'h04, 8'h00, 1'h0},
            '{1'h0, 8'h0D, 8'h00, 8'h04, 1'h0},
            '{1'h1, 8'h0D, 8'h00, 8'h00, 1'h0}
        };
        presetn = 1'b0;
        ce = 1'b1;
        conv_data = 48'h123456789ABC;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk(16'(dcs_enable), 16'h0001, "dcs reset");
        chk(16'(test_active), 16'h0000, "test reset");
        chk(16'(ch(0)), 16'h0ABC, "normal data");
        foreach (rows[i]) begin
            i_acr_host_model.xfer(rows[i].wr, rows[i].idx, rows[i].wd, rdv, errv);
            chk(16'(rdv), 16'(rows[i].exp), "row data");
            chk(16'(errv), 16'(rows[i].err), "row err");
        end
        chk(16'(data_clock_out_select), 16'h0000, "dco sel off");
        wr(8'h05, 8'h30);
        repeat (2) @(negedge pclk);
        chk(16'(data_clock_out_select), 16'h0001, "dco sel");
        chk(16'(frame_clock_out_select), 16'h0001, "fco sel");
        // Staged settings must stay inert until the commit write.
        wr(8'h09, 8'h00);
        wr(8'h08, 8'h05);
        wr(8'h14, 8'h41);
        wr(8'h05, 8'h01);
        wr(8'h0D, 8'h02);
        settle();
        chk(16'(dcs_enable), 16'h0001, "staged only");
        wr(8'hFF, 8'h01);
        settle();
        chk(16'(dcs_enable), 16'h0000, "dcs off");
        chk(16'(lvds_low_power), 16'h0001, "low power");
        chk(16'(chip_mode), 16'h0005, "modes");
        chk(16'(test_active), 16'h0001, "test ch0");
        chk(16'(ch(0)), 16'h07FF, "full scale twos");
        chk(16'(ch(1)), 16'h0F89, "live twos");
        wr(8'h14, 8'h04);
        wr(8'h05, 8'h02);
        wr(8'h0D, 8'h08);
        wr(8'h19, 8'h30);
        wr(8'h1A, 8'hAB);
        wr(8'hFF, 8'h01);
        settle();
        chk(16'(test_active), 16'h0003, "test ch1");
        chk(16'(ch(0)), 16'h0000, "inverted ones");
        chk(16'(ch(1)), 16'h054C, "user pattern");
        chk(16'(ch(3)), 16'h0EDC, "inverted live");
        wr(8'h05, 8'h08);
        for (int code = 0; code < 13; code++) begin
            wr(8'h0D, 8'(code));
            wr(8'hFF, 8'h01);
            settle();
            chk(16'(test_active[3]), 16'(code != 0), "code active");
            v1 = ch(3);
            @(negedge pclk);
            v2 = ch(3);
            if (code == 1) chk(16'(v1), 16'h07FF, "midscale");
            if (code == 7) begin
                chk(16'(v2 ^ v1), 16'h0FFF, "word toggle");
                chk(16'(v1 == 12'hFFF || v1 == 12'h000), 16'h0001, "toggle word");
            end
            if (code == 5 || code == 6) begin
                n = 0;
                repeat (40) begin
                    @(negedge pclk);
                    if (ch(3) !== v2) n++;
                end
                chk(16'(n > 0), 16'h0001, "pn moving");
            end
        end
        // A low enable must freeze the running sequence.
        wr(8'h0D, 8'h05);
        wr(8'hFF, 8'h01);
        settle();
        @(posedge pclk);
        ce <= 1'b0;
        @(negedge pclk);
        v1 = ch(3);
        repeat (5) @(negedge pclk);
        chk(16'(ch(3)), 16'(v1), "frozen by enable");
        @(posedge pclk);
        ce <= 1'b1;
        // Holding the long reset bit pins the sequence at its all-ones seed, inverted here.
        wr(8'h0D, 8'h25);
        wr(8'hFF, 8'h01);
        settle();
        v1 = ch(3);
        repeat (5) @(negedge pclk);
        chk(16'(v1), 16'h0000, "long seq held");
        chk(16'(ch(3)), 16'h0000, "long seq still");
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk(16'(dcs_enable), 16'h0001, "dcs in reset");
        chk(16'(test_active), 16'h0000, "test in reset");
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        i_acr_host_model.xfer(1'b0, 8'h05, 8'h00, rdv, errv);
        chk(16'(rdv), 16'h000F, "mask again");
        i_acr_host_model.xfer(1'b0, 8'h14, 8'h00, rdv, errv);
        chk(16'(rdv), 16'h0000, "format again");
        print_verdict();
    end
endmodule : tb_adc_channel_config_regs
